// file: common/timer_pkg.sv
// package: register map, field layout and reset values of the timer section
package timer_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_RUN_CONTROL  = 6'h0E;
  localparam logic [5:0] IDX_MODE_CONTROL = 6'h0F;
  localparam logic [5:0] IDX_RELOAD_HIGH  = 6'h10;
  localparam logic [5:0] IDX_RELOAD_LOW   = 6'h11;
  localparam logic [5:0] IDX_EVENT_STATUS = 6'h20;

  // ---------------------------------------------------------------
  // run control fields
  // ---------------------------------------------------------------
  localparam int RUN_FLAG_LSB  = 4;
  localparam int RUN_MASK_LSB  = 0;
  localparam int TIMER_COUNT   = 4;

  // ---------------------------------------------------------------
  // timer0 mode control fields
  // ---------------------------------------------------------------
  localparam int HALT_RX_BIT     = 7;
  localparam int START_MODE_LSB  = 4;
  localparam int RELOAD_ZERO_BIT = 3;
  localparam int CLK_SEL_LSB     = 0;

  // ---------------------------------------------------------------
  // event status fields
  // ---------------------------------------------------------------
  localparam int IRQ_FLAG_BIT = 0;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] START_NONE     = 2'h0;
  localparam logic [1:0] START_TX_END   = 2'h1;
  localparam logic [1:0] START_TRIM     = 2'h2;
  localparam logic [1:0] START_TRIM_UF  = 2'h3;
  localparam logic [1:0] CLK_CARRIER    = 2'h0;
  localparam logic [1:0] CLK_SLOW       = 2'h1;
  localparam logic [1:0] CLK_TIMER2_UF  = 2'h2;
  localparam logic [1:0] CLK_TIMER1_UF  = 2'h3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0]  RUN_RESET        = 4'h0;
  localparam logic [7:0]  MODE_RESET       = 8'h00;
  localparam logic [7:0]  RELOAD_RESET     = 8'h00;
  localparam logic [15:0] COUNT_RESET      = 16'h0000;
  localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;

endpackage

// file: logic/timer_tick_select.sv
// module: picks the count tick of timer 0 from four sources
`timescale 1ns/1ns
module timer_tick_select
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] clk_sel,
  input  wire logic       tick_carrier,
  input  wire logic       tick_slow,
  input  wire logic       timer1_underflow,
  input  wire logic       timer2_underflow,
  output logic            tick
);

  typedef struct packed
  {
    logic tick;
  } sel_state_t;

  sel_state_t st;
  sel_state_t next_st;

  // ---------------------------------------------------------------
  // source choice
  // ---------------------------------------------------------------
  // registered so the counter sees a clean single-cycle pulse
  always_comb
  begin
    next_st = st;
    case (clk_sel)
      timer_pkg::CLK_CARRIER:   next_st.tick = tick_carrier;
      timer_pkg::CLK_SLOW:      next_st.tick = tick_slow;
      timer_pkg::CLK_TIMER2_UF: next_st.tick = timer2_underflow;
      timer_pkg::CLK_TIMER1_UF: next_st.tick = timer1_underflow;
      default:                  next_st.tick = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

endmodule // timer_tick_select

// file: logic/timer_section.sv
// module: shared timer run control plus timer 0 configuration and counter
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
module timer_section
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tick_carrier,
  input  wire logic        tick_slow,
  input  wire logic        timer1_underflow,
  input  wire logic        timer2_underflow,
  input  wire logic [2:0]  others_stopped,
  input  wire logic        tx_end,
  input  wire logic        rx_nibble_done,
  input  wire logic        trim_edge,
  output logic [3:0]       timer_active,
  output logic             timer0_underflow,
  output logic             underflow_irq_flag
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed
  {
    logic [3:0]  run;
    logic        halt_on_receive;
    logic [1:0]  start_mode_select;
    logic        reload_on_zero;
    logic [1:0]  count_clock_select;
    logic [7:0]  reload_value_high;
    logic [7:0]  reload_value_low;
    logic [15:0] count;
    logic        irq;
    logic        uf_pulse;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  logic        tick;
  logic        access;
  logic        wr_done;
  logic [5:0]  idx;
  logic        hit;
  logic        trim_mode;
  logic [15:0] reload_value;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic [3:0]  stop_req;
  logic        count_step;
  logic        at_zero;
  logic        tx_start;
  logic        trim_flip;
  logic        rx_halt;
  logic        sw_write;

  // ---------------------------------------------------------------
  // tick source
  // ---------------------------------------------------------------
  timer_tick_select u_tick
  (
    .pclk             (pclk),
    .presetn          (presetn),
    .clk_sel          (st.count_clock_select),
    .tick_carrier     (tick_carrier),
    .tick_slow        (tick_slow),
    .timer1_underflow (timer1_underflow),
    .timer2_underflow (timer2_underflow),
    .tick             (tick)
  );

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // one wait state: pready rises in the second access cycle
  assign access  = psel && penable && !st.pready;
  assign wr_done = psel && penable && st.pready && pwrite;
  assign idx     = paddr[7:2];
  assign wbyte   = pwdata[7:0];
  // misaligned or unmapped addresses answer with pslverr
  assign hit     = (paddr[1:0] == 2'h0)
                   && (idx == timer_pkg::IDX_RUN_CONTROL
                    || idx == timer_pkg::IDX_MODE_CONTROL
                    || idx == timer_pkg::IDX_RELOAD_HIGH
                    || idx == timer_pkg::IDX_RELOAD_LOW
                    || idx == timer_pkg::IDX_EVENT_STATUS);

  assign trim_mode    = st.start_mode_select[1];
  assign reload_value = {st.reload_value_high, st.reload_value_low};

  // ---------------------------------------------------------------
  // stop requests of the other timers
  // ---------------------------------------------------------------
  // timers 1 to 3 count elsewhere and only report their stop here;
  // timer 0 stops through its own events below
  assign stop_req[0] = 1'b0;
  for (genvar g = 1; g < timer_pkg::TIMER_COUNT; g++)
  begin : g_stop
    assign stop_req[g] = others_stopped[g-1];
  end

  // ---------------------------------------------------------------
  // timer 0 events
  // ---------------------------------------------------------------
  // each event is named once so the next-state logic reads as a list
  assign count_step = st.run[0] && tick;
  assign at_zero    = (st.count == 16'h0000);
  assign tx_start   = tx_end
                      && st.start_mode_select == timer_pkg::START_TX_END;
  // trimming owns start and stop; a receive halt would fight it
  assign trim_flip  = trim_mode && trim_edge;
  assign rx_halt    = st.halt_on_receive && !trim_mode
                      && rx_nibble_done;
  assign sw_write   = wr_done && hit;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  // mask bits are write-only and read back as zero
  always_comb
  begin
    rbyte = 8'h00;
    case (idx)
      timer_pkg::IDX_RUN_CONTROL:
        rbyte[timer_pkg::RUN_FLAG_LSB +: 4] = st.run;
      timer_pkg::IDX_MODE_CONTROL:
      begin
        // reserved bits 6 and 2 stay zero
        rbyte[timer_pkg::HALT_RX_BIT]         = st.halt_on_receive;
        rbyte[timer_pkg::START_MODE_LSB +: 2] = st.start_mode_select;
        rbyte[timer_pkg::RELOAD_ZERO_BIT]     = st.reload_on_zero;
        rbyte[timer_pkg::CLK_SEL_LSB +: 2]    = st.count_clock_select;
      end
      timer_pkg::IDX_RELOAD_HIGH:
        rbyte = st.reload_value_high;
      timer_pkg::IDX_RELOAD_LOW:
        rbyte = st.reload_value_low;
      timer_pkg::IDX_EVENT_STATUS:
        rbyte[timer_pkg::IRQ_FLAG_BIT] = st.irq;
      default:
        rbyte = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st          = st;
    next_st.uf_pulse = 1'b0;

    // apb answer; data and error stand only while pready is high
    next_st.pready  = access;
    next_st.pslverr = 1'b0;
    next_st.prdata  = timer_pkg::RDATA_RESET;
    if (access)
    begin
      next_st.pslverr = !hit;
      next_st.prdata  = (hit && !pwrite) ? {24'h000000, rbyte}
                                         : timer_pkg::RDATA_RESET;
    end

    // other timers report their own stop
    next_st.run = st.run & ~stop_req;

    // counting; reload only read at a start or at an underflow with reload_on_zero, not mid-count
    if (count_step)
    begin
      if (!at_zero)
        next_st.count = st.count - 16'h0001;
      else if (st.start_mode_select == timer_pkg::START_TRIM)
        next_st.run[0] = 1'b0;
      else
      begin
        // decrement at zero is an underflow
        next_st.uf_pulse = 1'b1;
        next_st.irq      = 1'b1;
        if (st.reload_on_zero)
          next_st.count = reload_value;
        else
          next_st.run[0] = 1'b0;
      end
    end

    // automatic start at end of transmission
    if (tx_start)
    begin
      next_st.run[0] = 1'b1;
      next_st.count  = reload_value;
    end

    // trimming: each rising edge toggles start and stop
    if (trim_flip)
    begin
      next_st.run[0] = !st.run[0];
      if (!st.run[0])
        next_st.count = reload_value;
    end

    // receive halt, which trimming overrides
    if (rx_halt)
      next_st.run[0] = 1'b0;

    // software writes last, so software wins over events, except an irq clear against an underflow in the same cycle
    if (sw_write)
    begin
      case (idx)
        timer_pkg::IDX_RUN_CONTROL:
        begin
          for (int i = 0; i < timer_pkg::TIMER_COUNT; i++)
          begin
            if (wbyte[timer_pkg::RUN_MASK_LSB + i])
            begin
              next_st.run[i] = wbyte[timer_pkg::RUN_FLAG_LSB + i];
              if (i == 0 && wbyte[timer_pkg::RUN_FLAG_LSB])
                next_st.count = reload_value;
            end
          end
        end
        timer_pkg::IDX_MODE_CONTROL:
        begin
          next_st.halt_on_receive    = wbyte[timer_pkg::HALT_RX_BIT];
          next_st.start_mode_select  =
            wbyte[timer_pkg::START_MODE_LSB +: 2];
          next_st.reload_on_zero     = wbyte[timer_pkg::RELOAD_ZERO_BIT];
          next_st.count_clock_select = wbyte[timer_pkg::CLK_SEL_LSB +: 2];
        end
        timer_pkg::IDX_RELOAD_HIGH:
          next_st.reload_value_high = wbyte;
        timer_pkg::IDX_RELOAD_LOW:
          next_st.reload_value_low = wbyte;
        timer_pkg::IDX_EVENT_STATUS:
        begin
          // write one clears; a fresh underflow in the same cycle wins
          if (wbyte[timer_pkg::IRQ_FLAG_BIT] && !next_st.uf_pulse)
            next_st.irq = 1'b0;
        end
        default:
          next_st.irq = next_st.irq;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // the whole state is one register; reset clears it, then loads run, halt, reload, count and read data from the package
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st                    <= '0;
      st.run                <= timer_pkg::RUN_RESET;
      st.halt_on_receive    <= timer_pkg::MODE_RESET[timer_pkg::HALT_RX_BIT];
      st.reload_value_high  <= timer_pkg::RELOAD_RESET;
      st.reload_value_low   <= timer_pkg::RELOAD_RESET;
      st.count              <= timer_pkg::COUNT_RESET;
      st.prdata             <= timer_pkg::RDATA_RESET;
    end
    else
      st <= next_st;
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign prdata             = st.prdata;
  assign pready             = st.pready;
  assign pslverr            = st.pslverr;
  assign timer_active       = st.run;
  assign timer0_underflow   = st.uf_pulse;
  assign underflow_irq_flag = st.irq;

endmodule // timer_section

// file: verification/timer_section_monitor.sv
// checker: port-level properties of the timer section
`timescale 1ns/1ns
module timer_section_monitor
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tick_carrier,
  input wire logic        tick_slow,
  input wire logic        timer1_underflow,
  input wire logic        timer2_underflow,
  input wire logic [2:0]  others_stopped,
  input wire logic        tx_end,
  input wire logic        rx_nibble_done,
  input wire logic        trim_edge,
  input wire logic [3:0]  timer_active,
  input wire logic        timer0_underflow,
  input wire logic        underflow_irq_flag
);
  // ---------------------------------------------------------------
  // decoded bus events
  // ---------------------------------------------------------------
  logic acc;
  logic run_wr;
  logic irq_clr;
  logic mapped;
  // the completing edge is the only one where a write lands
  assign acc     = psel && penable && pready;
  assign run_wr  = acc && pwrite && paddr == 8'h38;
  assign irq_clr = acc && pwrite && paddr == 8'h80 && pwdata[0];
  assign mapped  = paddr inside {8'h38, 8'h3C, 8'h40, 8'h44, 8'h80};

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stood more than one cycle");
  chk_wait_state: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero outside answer");
  chk_err_unmapped: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  chk_masked_update: assert property (run_wr |=>
    ((timer_active ^ $past(pwdata[7:4])) & $past(pwdata[3:0])) == 4'h0)
    else $error("masked run bit not written");
  chk_unmasked_keep: assert property (run_wr && pwdata[3:1] == 3'h0
    && others_stopped == 3'h0 |=> $stable(timer_active[3:1]))
    else $error("unmasked run bit changed");
  chk_stop_pulse: assert property (others_stopped[0] && !run_wr
    |=> !timer_active[1])
    else $error("stop event left timer 1 running");
  chk_irq_follows: assert property (timer0_underflow |-> underflow_irq_flag)
    else $error("underflow without irq flag");
  chk_uf_running: assert property (timer0_underflow |-> $past(timer_active[0]))
    else $error("underflow while stopped");
  chk_irq_sticky: assert property (underflow_irq_flag && !irq_clr
    |=> underflow_irq_flag)
    else $error("irq flag dropped without clear");
endmodule // timer_section_monitor

bind timer_section timer_section_monitor i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tick_carrier(tick_carrier), .tick_slow(tick_slow),
  .timer1_underflow(timer1_underflow), .timer2_underflow(timer2_underflow),
  .others_stopped(others_stopped), .tx_end(tx_end),
  .rx_nibble_done(rx_nibble_done), .trim_edge(trim_edge),
  .timer_active(timer_active), .timer0_underflow(timer0_underflow),
  .underflow_irq_flag(underflow_irq_flag));

// file: verification/tb.sv
// testbench: register access and timer 0 behaviour of the timer section
`timescale 1ns/1ns
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, v;
  logic [31:0] pwdata, prdata;
  logic [9:0]  stim;
  logic [3:0]  timer_active, m;
  logic        uf, irq;
  logic [32:0] expq[$];
  logic [32:0] e;
  int          failures, num_checks, i, k, n_uf;
  localparam logic [7:0] RUN = 8'h38;
  localparam logic [7:0] MODE = 8'h3C;
  localparam logic [7:0] HI = 8'h40;
  localparam logic [7:0] LO = 8'h44;
  localparam logic [7:0] EVT = 8'h80;

  // stim: 0 carrier, 1 slow, 2/3 timer2/1 underflow, 4 tx, 5 rx, 6 trim
  timer_section i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tick_carrier(stim[0]), .tick_slow(stim[1]),
    .timer2_underflow(stim[2]), .timer1_underflow(stim[3]),
    .tx_end(stim[4]), .rx_nibble_done(stim[5]), .trim_edge(stim[6]),
    .others_stopped(stim[9:7]), .timer_active(timer_active),
    .timer0_underflow(uf), .underflow_irq_flag(irq));

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // bus driver, result watcher and compares
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, d,
                     input logic [32:0] x);
    int n;
    n = 0;
    expq.push_back(x);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // the slave sets the pace; only a hang bound ends the wait
    while (pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, x);
    apb(1'b0, a, 8'h00, {25'h0, x});
  endtask

  task automatic pulse(input int b, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      stim[b] <= 1'b1;
      @(posedge pclk);
      stim[b] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  task automatic cmp_word(input logic [31:0] x, y);
    num_checks++;
    if (x !== y)
    begin
      failures++;
      $display("mismatch prdata expected %h seen %h", x, y);
    end
  endtask

  task automatic cmp_err(input logic x, y);
    num_checks++;
    if (x !== y)
    begin
      failures++;
      $display("mismatch pslverr expected %b seen %b", x, y);
    end
  endtask

  task automatic cmp_irq(input logic x, y);
    num_checks++;
    if (x !== y)
    begin
      failures++;
      $display("mismatch underflow_irq_flag expected %b seen %b", x, y);
    end
  endtask

  task automatic cmp_uf(input int x);
    num_checks++;
    if (x != n_uf)
    begin
      failures++;
      $display("mismatch timer0_underflow count expected %0d seen %0d",
               x, n_uf);
    end
  endtask

  // oldest note is matched against each completed transfer
  always @(posedge pclk)
  begin
    if (uf === 1'b1) n_uf++;
    if (psel && penable && pready === 1'b1)
    begin
      e = expq.pop_front();
      cmp_err(e[32], pslverr);
      if (!pwrite) cmp_word(e[31:0], prdata);
      if (!pwrite && paddr == EVT) cmp_irq(e[0], irq);
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    failures++;
    tally_and_finish;
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, stim} = '0;
    presetn = 1'b0;
    i = $urandom(98178);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(RUN, 8'h00);
    rd(MODE, 8'h00);
    rd(HI, 8'h00);
    rd(LO, 8'h00);
    rd(EVT, 8'h00);
    apb(1'b0, 8'h84, 8'h00, {1'b1, 32'h0});
    $display("test reset done");
    wr(RUN, 8'hFF);
    rd(RUN, 8'hF0);
    wr(RUN, 8'hF0);
    rd(RUN, 8'hF0);
    m = 4'hF;
    for (i = 0; i < 8; i++)
    begin
      v = $urandom;
      m = (m & ~v[3:0]) | (v[7:4] & v[3:0]);
      wr(RUN, v);
      rd(RUN, {m, 4'h0});
    end
    for (k = 7; k < 10; k++) pulse(k, 1);
    rd(RUN, {3'h0, m[0], 4'h0});
    v = $urandom;
    wr(MODE, v);
    rd(MODE, v & 8'hBB);
    wr(RUN, 8'h01);
    $display("test masked write done");
    // each source counts alone; a reload change waits for the next start
    wr(HI, 8'h00);
    for (k = 0; k < 4; k++)
    begin
      wr(MODE, 8'(k));
      wr(LO, 8'h02);
      wr(RUN, 8'h11);
      wr(LO, 8'h09);
      pulse((k + 1) % 4, 3);
      pulse(k, 2);
      rd(RUN, 8'h10);
      pulse(k, 1);
      rd(RUN, 8'h00);
      rd(EVT, 8'h01);
      wr(EVT, 8'h01);
      rd(EVT, 8'h00);
    end
    wr(MODE, 8'h01);
    wr(HI, 8'h01);
    wr(LO, 8'h00);
    wr(RUN, 8'h11);
    pulse(1, 256);
    rd(RUN, 8'h10);
    pulse(1, 1);
    rd(RUN, 8'h00);
    cmp_uf(5);
    $display("test clock select done");
    wr(MODE, 8'h09);
    wr(HI, 8'h00);
    wr(LO, 8'h01);
    wr(RUN, 8'h11);
    pulse(1, 2);
    rd(RUN, 8'h10);
    wr(EVT, 8'h01);
    pulse(1, 2);
    rd(EVT, 8'h01);
    wr(RUN, 8'h01);
    wr(EVT, 8'h01);
    cmp_uf(7);
    $display("test restart done");
    wr(MODE, 8'h01);
    pulse(4, 1);
    rd(RUN, 8'h00);
    wr(MODE, 8'h11);
    pulse(4, 1);
    rd(RUN, 8'h10);
    wr(MODE, 8'h91);
    pulse(5, 1);
    rd(RUN, 8'h00);
    for (k = 2; k < 4; k++)
    begin
      wr(MODE, {2'b10, k[1:0], 4'h1});
      pulse(6, 1);
      pulse(5, 1);
      rd(RUN, 8'h10);
      pulse(1, 2);
      rd(RUN, 8'h00);
      rd(EVT, {7'h0, k == 3});
      wr(EVT, 8'h01);
    end
    cmp_uf(8);
    $display("test start modes done");
    tally_and_finish;
  end
endmodule // tb
